// ### hdl/pced_defines.vh
// Register map, field layout, reset values and widths for pin change detect
`ifndef PCED_DEFINES_VH
`define PCED_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCED_OFF_RISE      12'h000
`define PCED_OFF_FALL      12'h004
`define PCED_OFF_FLAG      12'h008
`define PCED_OFF_CTRL      12'h00c
`define PCED_OFF_STAT      12'h010

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define PCED_PINS          6
`define PCED_ADDR_W        12
`define PCED_CTRL_IE_BIT   0
`define PCED_CTRL_SLP_BIT  1
`define PCED_STAT_IF_BIT   0
`define PCED_STAT_IRQ_BIT  1
`define PCED_STAT_SLP_BIT  2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PCED_RST_EN        6'h00
`define PCED_RST_FLAG      6'h00
`define PCED_RST_CTRL      2'h0

`endif

// ### hdl/pced_pin_sync.v
// Two-stage synchroniser with edge detector for one port pin
`timescale 1ns/1ps
`default_nettype none

module pced_pin_sync (
    // Clock and reset
    input  wire CLK_IN,
    input  wire RST_IN,
    // Pin and edge outputs
    input  wire pin_in,
    output wire rise_out,
    output wire fall_out
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    // Reset value 0: a pin high at reset shows one rising edge
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;

endmodule // pced_pin_sync

`default_nettype wire

// ### hdl/pced_top.v
// APB pin change edge detector: six pins, per-edge enables, sticky flags
//
// Contract
// - A flag clear written in the cycle a new enabled edge arrives leaves the flag set.
// - In sleep an enabled edge wakes the device only while the int enable is set.
// - An edge caught in sleep is in the flag register before wake is signalled.
// - Six rising enable bits 5..0 arm rising detection per pin.
// - Six falling enable bits 5..0 arm falling detection per pin.
// - A cleared enable bit hides that polarity from flag and interrupt.
// - Flag x sets on an enabled rising or falling edge of pin x.
// - A flag stays set until software clears it or reset.
// - Bits 7 and 6 of enable and flag registers read zero, ignore writes.
// - Detection and flag setting go on while the int enable is clear.
// - The summary flag is the OR of all pin flags.
// - Both enables set detect both polarities on a pin.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pced_defines.vh"

module pced_top #(
    parameter PINS = `PCED_PINS
) (
    // Clock and reset
    input  wire                    CLK_IN,
    input  wire                    RST_IN,
    // APB slave
    input  wire                    PSEL_IN,
    input  wire                    PENABLE_IN,
    input  wire                    PWRITE_IN,
    input  wire [`PCED_ADDR_W-1:0] PADDR_IN,
    input  wire [31:0]             PWDATA_IN,
    input  wire [3:0]              PSTRB_IN,
    output reg  [31:0]             PRDATA_OUT,
    output wire                    PREADY_OUT,
    output wire                    PSLVERR_OUT,
    // Port pins
    input  wire [PINS-1:0]         PORT_A_PIN_IN,
    // Interrupt and wake
    output reg                     IRQ_OUT,
    output reg                     WAKE_OUT,
    output wire                    CHANGE_INT_FLAG_OUT
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [PINS-1:0] rise_en_q;
    reg  [PINS-1:0] fall_en_q;
    reg  [PINS-1:0] flag_q;
    reg  [PINS-1:0] flag_d;
    reg             int_en_q;
    reg             sleep_q;
    reg  [31:0]     rdata_d;

    wire [PINS-1:0] rise_w;
    wire [PINS-1:0] fall_w;
    wire [PINS-1:0] hit_w;
    wire            access_w;
    wire            wr_w;
    wire            sel_rise_w;
    wire            sel_fall_w;
    wire            sel_flag_w;
    wire            sel_ctrl_w;
    wire            sel_stat_w;
    wire            mapped_w;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            pced_pin_sync u_sync (
                .CLK_IN   (CLK_IN),
                .RST_IN   (RST_IN),
                .pin_in   (PORT_A_PIN_IN[g]),
                .rise_out (rise_w[g]),
                .fall_out (fall_w[g])
            );
        end
    endgenerate

    // Enabled edges; int enable deliberately not in this path
    assign hit_w = (rise_w & rise_en_q) | (fall_w & fall_en_q);

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Zero wait states: every access finishes in its first access cycle
    assign PREADY_OUT  = 1'b1;
    assign access_w    = PSEL_IN & PENABLE_IN;
    assign wr_w        = access_w & PWRITE_IN & PSTRB_IN[0];
    assign sel_rise_w  = (PADDR_IN == `PCED_OFF_RISE);
    assign sel_fall_w  = (PADDR_IN == `PCED_OFF_FALL);
    assign sel_flag_w  = (PADDR_IN == `PCED_OFF_FLAG);
    assign sel_ctrl_w  = (PADDR_IN == `PCED_OFF_CTRL);
    assign sel_stat_w  = (PADDR_IN == `PCED_OFF_STAT);
    assign mapped_w    = sel_rise_w | sel_fall_w | sel_flag_w |
                         sel_ctrl_w | sel_stat_w;
    assign PSLVERR_OUT = access_w & ~mapped_w;

    // ------------------------------------------------------------------
    // Flag next value
    // ------------------------------------------------------------------
    // Set wins over a write, so a clear never swallows a fresh edge
    always @* begin
        flag_d = flag_q;
        if (wr_w && sel_flag_w) begin
            flag_d = PWDATA_IN[PINS-1:0];
        end
        flag_d = flag_d | hit_w;
    end

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rise_en_q <= `PCED_RST_EN;
            fall_en_q <= `PCED_RST_EN;
            flag_q    <= `PCED_RST_FLAG;
            int_en_q  <= 1'b0;
            sleep_q   <= 1'b0;
        end else begin
            flag_q <= flag_d;
            if (wr_w && sel_rise_w) begin
                rise_en_q <= PWDATA_IN[PINS-1:0];
            end
            if (wr_w && sel_fall_w) begin
                fall_en_q <= PWDATA_IN[PINS-1:0];
            end
            if (wr_w && sel_ctrl_w) begin
                int_en_q <= PWDATA_IN[`PCED_CTRL_IE_BIT];
                sleep_q  <= PWDATA_IN[`PCED_CTRL_SLP_BIT];
            end else if (sleep_q && int_en_q && (|flag_q)) begin
                // Flag is already stored when sleep is left
                sleep_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt and wake outputs
    // ------------------------------------------------------------------
    assign CHANGE_INT_FLAG_OUT = |flag_q;

    // Wake follows the stored flag, one cycle after it is set
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT  <= 1'b0;
            WAKE_OUT <= 1'b0;
        end else begin
            IRQ_OUT  <= (|flag_d) & int_en_q;
            WAKE_OUT <= sleep_q & int_en_q & (|flag_q);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        if (sel_rise_w) begin
            rdata_d[PINS-1:0] = rise_en_q;
        end else if (sel_fall_w) begin
            rdata_d[PINS-1:0] = fall_en_q;
        end else if (sel_flag_w) begin
            rdata_d[PINS-1:0] = flag_q;
        end else if (sel_ctrl_w) begin
            rdata_d[`PCED_CTRL_IE_BIT]  = int_en_q;
            rdata_d[`PCED_CTRL_SLP_BIT] = sleep_q;
        end else if (sel_stat_w) begin
            rdata_d[`PCED_STAT_IF_BIT]  = |flag_q;
            rdata_d[`PCED_STAT_IRQ_BIT] = IRQ_OUT;
            rdata_d[`PCED_STAT_SLP_BIT] = sleep_q;
        end
    end

    // Data held in a flop; captured in setup so it stands in access
    always @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0000_0000;
        end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            PRDATA_OUT <= rdata_d;
        end
    end

endmodule // pced_top

`default_nettype wire

// ### tb/pced_props.sv
// Checker for the pin change edge detector ports
`timescale 1ns/1ps
`default_nettype none
`include "pced_defines.vh"
module pced_props #(parameter PINS = 6) (
    // Clock, reset and bus
    input wire logic                    CLK_IN,
    input wire logic                    RST_IN,
    input wire logic                    PSEL_IN,
    input wire logic                    PENABLE_IN,
    input wire logic                    PWRITE_IN,
    input wire logic [`PCED_ADDR_W-1:0] PADDR_IN,
    input wire logic [31:0]             PRDATA_OUT,
    // Pins and events
    input wire logic [PINS-1:0]         PORT_A_PIN_IN,
    input wire logic                    IRQ_OUT,
    input wire logic                    WAKE_OUT,
    input wire logic                    CHANGE_INT_FLAG_OUT
);
    wire rd = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
    wire wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
    default clocking dcb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    AST_IRQ_FLAG: assert property (IRQ_OUT |-> CHANGE_INT_FLAG_OUT)
        else $error("irq without flag");
    AST_WAKE_AFTER: assert property (WAKE_OUT |-> $past(CHANGE_INT_FLAG_OUT))
        else $error("wake before flag");
    AST_FLAG_HOLD: assert property (CHANGE_INT_FLAG_OUT && !wr |=> CHANGE_INT_FLAG_OUT)
        else $error("flag dropped");
    // Exact three edge latency: a looser bound would hide a lost stage
    AST_FLAG_CAUSE: assert property ($rose(CHANGE_INT_FLAG_OUT) |->
        $past(wr) || $past(PORT_A_PIN_IN, 3) != $past(PORT_A_PIN_IN, 4))
        else $error("flag without cause");
    AST_RSV_ZERO: assert property (rd && PADDR_IN < 12'h00c |-> PRDATA_OUT[31:6] == 26'h0)
        else $error("reserved bits set");
    AST_CIF_OR: assert property (rd && PADDR_IN == 12'h008 |->
        (|PRDATA_OUT[5:0]) == $past(CHANGE_INT_FLAG_OUT))
        else $error("summary flag wrong");
    // A control write raises the request one edge later than a flag write
    AST_IRQ_RISE: assert property ($rose(IRQ_OUT) |->
        $rose(CHANGE_INT_FLAG_OUT) || $past(wr) || $past(wr, 2))
        else $error("irq rose without cause");
    AST_STATUS: assert property (rd && PADDR_IN == 12'h010 |->
        PRDATA_OUT[1:0] == {$past(IRQ_OUT), $past(CHANGE_INT_FLAG_OUT)})
        else $error("status mismatch");
endmodule // pced_props
bind pced_top pced_props #(.PINS(PINS)) u_props (.CLK_IN, .RST_IN, .PSEL_IN,
    .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PRDATA_OUT, .PORT_A_PIN_IN, .IRQ_OUT,
    .WAKE_OUT, .CHANGE_INT_FLAG_OUT);
`default_nettype wire

// ### tb/pced_pin_model.sv
// Model of the external signals on the port pins
`timescale 1ns/1ps
`default_nettype none
module pced_pin_model (
    // Clock
    input  wire logic       clk_in,
    // Pins
    output var  logic [5:0] pins_out
);
    initial pins_out = 6'h00;
    // Change just after an edge so timing is deterministic
    task automatic drive(input logic [5:0] v);
        @(posedge clk_in);
        pins_out <= v;
    endtask
endmodule // pced_pin_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the pin change edge detector
`timescale 1ns/1ps
`default_nettype none
`include "pced_defines.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %0t value", $time); end end
module testbench;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, perr, irq, wake, cif, e, seen;
    logic [5:0]  pins;
    int          miscompares = 0, checked = 0;
    initial forever #12.5 clk = ~clk;
    pced_top DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
        .PORT_A_PIN_IN(pins), .IRQ_OUT(irq), .WAKE_OUT(wake),
        .CHANGE_INT_FLAG_OUT(cif));
    pced_pin_model PM (.clk_in(clk), .pins_out(pins));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(q, x)
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
        apb(1'b1, `PCED_OFF_RISE, 32'hff);
        rd(`PCED_OFF_RISE, 32'h3f);
        pstrb <= 4'he;
        apb(1'b1, `PCED_OFF_RISE, 32'h0);
        pstrb <= 4'hf;
        rd(`PCED_OFF_RISE, 32'h3f);
        apb(1'b1, `PCED_OFF_FALL, 32'hc0);
        rd(`PCED_OFF_FALL, 32'h0);
        rd(12'h020, 32'h0);
        `CHK(e, 1'b1)
        $display("registers done");
        PM.drive(6'h3f);
        repeat (4) @(posedge clk);
        rd(`PCED_OFF_FLAG, 32'h3f);
        `CHK(cif, 1'b1)
        `CHK(irq, 1'b0)
        PM.drive(6'h00);
        repeat (4) @(posedge clk);
        rd(`PCED_OFF_FLAG, 32'h3f);
        apb(1'b1, `PCED_OFF_FLAG, q & ~32'h3f);
        apb(1'b1, `PCED_OFF_RISE, 32'h0);
        apb(1'b1, `PCED_OFF_FALL, 32'h3f);
        PM.drive(6'h2a);
        repeat (4) @(posedge clk);
        rd(`PCED_OFF_FLAG, 32'h0);
        PM.drive(6'h00);
        repeat (4) @(posedge clk);
        rd(`PCED_OFF_FLAG, 32'h2a);
        $display("edges done");
        apb(1'b1, `PCED_OFF_FLAG, 32'h0);
        apb(1'b1, `PCED_OFF_RISE, 32'h1);
        apb(1'b1, `PCED_OFF_FALL, 32'h1);
        PM.drive(6'h01);
        apb(1'b1, `PCED_OFF_FLAG, 32'h0);
        rd(`PCED_OFF_FLAG, 32'h1);
        apb(1'b1, `PCED_OFF_CTRL, 32'h1);
        rd(`PCED_OFF_STAT, 32'h3);
        apb(1'b1, `PCED_OFF_FLAG, 32'h0);
        rd(`PCED_OFF_STAT, 32'h0);
        `CHK(irq, 1'b0)
        $display("clear and irq done");
        apb(1'b1, `PCED_OFF_CTRL, 32'h3);
        PM.drive(6'h00);
        for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
        `CHK(wake, 1'b1)
        `CHK(cif, 1'b1)
        apb(1'b1, `PCED_OFF_FLAG, 32'h0);
        apb(1'b1, `PCED_OFF_CTRL, 32'h2);
        PM.drive(6'h01);
        seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            seen = seen | wake;
        end
        `CHK(seen, 1'b0)
        rd(`PCED_OFF_FLAG, 32'h1);
        $display("sleep done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`PCED_OFF_FLAG, 32'h0);
        rd(`PCED_OFF_CTRL, 32'h0);
        $display("reset done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
